// ### inc/spg_pkg.sv
package spg_pkg;

  // Timebase
  localparam int CLK_MHZ = 100;                 // Cycles per microsecond
  localparam int CYC_PER_MS = CLK_MHZ * 1000;   // Cycles per millisecond

  // Pulses-per-kilometre constant limits and width
  localparam int K_W = 15;
  localparam logic [K_W-1:0] K_MIN = 15'h0fa0;  // 4000 pulses per km
  localparam logic [K_W-1:0] K_MAX = 15'h61a8;  // 25000 pulses per km

  // Speed pulse width numerator: 16000 ms-pulses per km
  localparam int SPD_WIDTH_MS_K = 16000;
  localparam logic [31:0] SPD_WIDTH_NUM =
    32'(SPD_WIDTH_MS_K * CYC_PER_MS);           // 1.6e9 fits 31 bits
  localparam int SPD_W = 19;                    // Holds up to 400000
  localparam logic [SPD_W-1:0] SPD_WIDTH_RST =
    SPD_W'(SPD_WIDTH_MS_K * CYC_PER_MS / 4000); // Width at k = 4000
  localparam logic [SPD_W-1:0] SPD_WIDTH_MIN =
    SPD_W'(SPD_WIDTH_MS_K * CYC_PER_MS / 25000);

  // Distance output
  localparam logic [15:0] DIST_EDGES_PER_KM = 16'h0fa0; // 4000, 250 mm
  localparam int DIST_WIDTH_US = 1600;                  // 1.6 ms least
  localparam int DIST_WIDTH_CYC = DIST_WIDTH_US * CLK_MHZ;

  // Divider timing
  localparam logic [4:0] DIV_LAST = 5'h1f;     // 32 quotient bits

  // Divider states
  typedef enum logic [1:0] {
    DIV_IDLE = 2'b01,
    DIV_RUN = 2'b10
  } spg_div_state_t;

endpackage

// ### inc/spg_pulse_if.sv
`timescale 1ns/1ps
// Start and length of a fixed-width pulse, and its running level
interface spg_pulse_if #(parameter int W = 19);
  logic start;          // One-cycle launch, restarts a running pulse
  logic [W-1:0] len;    // High time in cycles, at least one
  logic active;         // Pulse level, from a flip-flop
  modport ctrl (output start, output len, input active);
  modport timer (input start, input len, output active);
endinterface

// ### src/spg_pulse_timer.sv
`timescale 1ns/1ps
// Fixed-width pulse: high for exactly len cycles after start
module spg_pulse_timer
  import spg_pkg::*;
#(
  parameter int W = 19
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  spg_pulse_if.timer pif
);

  logic [W-1:0] cnt_ff;      // Cycles of high time still to run
  logic [W-1:0] nxt_cnt;
  logic out_ff;              // Pulse level
  logic nxt_out;
  logic [W-1:0] lenHold_ff;  // Length taken at start, for checking
  logic [W-1:0] nxt_lenHold;
  logic [W-1:0] hiCnt_ff;    // High cycles so far, for checking
  logic [W-1:0] nxt_hiCnt;

  assign pif.active = out_ff;

  // Next state: a start always wins so back-to-back edges retrigger
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_out = out_ff;
    nxt_lenHold = lenHold_ff;
    nxt_hiCnt = hiCnt_ff;
    if (pif.start) begin
      nxt_cnt = pif.len;
      nxt_out = 1'b1;
      nxt_lenHold = pif.len;
      nxt_hiCnt = W'(1);
    end else if (out_ff) begin
      // Last high cycle drops the level on the next edge
      if (cnt_ff <= W'(1)) begin
        nxt_cnt = '0;
        nxt_out = 1'b0;
      end else begin
        nxt_cnt = cnt_ff - W'(1);
        nxt_hiCnt = hiCnt_ff + W'(1);
      end
    end
  end

  // Registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      out_ff <= 1'b0;
      lenHold_ff <= '0;
      hiCnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
      lenHold_ff <= nxt_lenHold;
      hiCnt_ff <= nxt_hiCnt;
    end
  end

  // High time equals the length given at start
  a_pulse_exact_width: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(out_ff) |-> ($past(hiCnt_ff) == $past(lenHold_ff)))
    else $error("pulse high time differs from its length");

endmodule // spg_pulse_timer

// ### src/spg_speed_pulse_gen.sv
`timescale 1ns/1ps
// Speed pulse and 4-per-metre distance regenerator
module spg_speed_pulse_gen
  import spg_pkg::*;
#(
  parameter int DIST_PULSE_CYC = DIST_WIDTH_CYC  // Distance high time
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sensorIn,          // Motion sensor speed pin
  input wire logic [K_W-1:0] pulsesPerKm, // Constant k, quasi-static
  output logic speedOut,              // Regenerated speed pulse
  output logic distanceOut            // Optional 4 pulses per metre
);

  localparam logic [SPD_W-1:0] DIST_LEN = SPD_W'(DIST_PULSE_CYC);

  // Input synchroniser and filtered level
  logic [2:0] sensSync_ff;   // Pin through three flip-flops
  logic [2:0] nxt_sensSync;
  logic sensLvl_ff;          // Level accepted when stages 2 and 3 agree
  logic nxt_sensLvl;
  logic sensRise;            // One cycle per accepted rising edge

  // Width divider
  spg_div_state_t divState_ff, nxt_divState;
  logic [4:0] divCnt_ff, nxt_divCnt;       // Quotient bit index
  logic [K_W:0] divRem_ff, nxt_divRem;     // Partial remainder
  logic [31:0] divQuo_ff, nxt_divQuo;      // Quotient being built
  logic [K_W-1:0] divK_ff, nxt_divK;       // Divisor of the latest width division
  logic [SPD_W-1:0] width_ff, nxt_width;   // Speed high time, cycles
  logic [K_W-1:0] kEff;                    // Clamped constant
  logic divStart;
  logic [K_W:0] remShift;

  // Distance accumulator
  logic [15:0] distAcc_ff, nxt_distAcc;    // Sub-250 mm remainder
  logic distPend_ff, nxt_distPend;         // Edge waiting to go out
  logic [15:0] accSum;
  logic distHit;

  spg_pulse_if #(.W(SPD_W)) spdIf ();
  spg_pulse_if #(.W(SPD_W)) distIf ();

  // Input filter: stage 1 is read only by stage 2
  always_comb begin
    nxt_sensSync = {sensSync_ff[1:0], sensorIn};
    nxt_sensLvl = sensLvl_ff;
    if (sensSync_ff[1] == sensSync_ff[2]) begin
      nxt_sensLvl = sensSync_ff[2];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sensSync_ff <= 3'h0;
      sensLvl_ff <= 1'b0;
    end else begin
      sensSync_ff <= nxt_sensSync;
      sensLvl_ff <= nxt_sensLvl;
    end
  end

  // Fixed latency of a few cycles, no jitter beyond one cycle
  assign sensRise = sensSync_ff[1] & sensSync_ff[2] & ~sensLvl_ff;

  // Out-of-range constants are held to the legal span
  always_comb begin
    if (pulsesPerKm < K_MIN) begin
      kEff = K_MIN;
    end else if (pulsesPerKm > K_MAX) begin
      kEff = K_MAX;
    end else begin
      kEff = pulsesPerKm;
    end
  end

  // Serial divide of the width numerator by k; the old width stays in
  // use for the 33 cycles a new k takes, trading speed for area
  assign divStart = (divState_ff == DIV_IDLE) && (kEff != divK_ff);
  assign remShift = {divRem_ff[K_W-1:0], SPD_WIDTH_NUM[5'h1f - divCnt_ff]};

  always_comb begin
    nxt_divState = divState_ff;
    nxt_divCnt = divCnt_ff;
    nxt_divRem = divRem_ff;
    nxt_divQuo = divQuo_ff;
    nxt_divK = divK_ff;
    nxt_width = width_ff;
    case (divState_ff)
      DIV_IDLE: begin
        if (divStart) begin
          nxt_divState = DIV_RUN;
          nxt_divK = kEff;
          nxt_divCnt = 5'h0;
          nxt_divRem = '0;
          nxt_divQuo = 32'h0;
        end
      end
      DIV_RUN: begin
        // Restoring step, one quotient bit per cycle
        if (remShift >= {1'b0, divK_ff}) begin
          nxt_divRem = remShift - {1'b0, divK_ff};
          nxt_divQuo = {divQuo_ff[30:0], 1'b1};
        end else begin
          nxt_divRem = remShift;
          nxt_divQuo = {divQuo_ff[30:0], 1'b0};
        end
        nxt_divCnt = divCnt_ff + 5'h1;
        if (divCnt_ff == DIV_LAST) begin
          nxt_divState = DIV_IDLE;
          nxt_width = nxt_divQuo[SPD_W-1:0];
        end
      end
      default: begin
        nxt_divState = DIV_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      divState_ff <= DIV_IDLE;
      divCnt_ff <= 5'h0;
      divRem_ff <= '0;
      divQuo_ff <= 32'h0;
      divK_ff <= K_MIN;
      width_ff <= SPD_WIDTH_RST;
    end else begin
      divState_ff <= nxt_divState;
      divCnt_ff <= nxt_divCnt;
      divRem_ff <= nxt_divRem;
      divQuo_ff <= nxt_divQuo;
      divK_ff <= nxt_divK;
      width_ff <= nxt_width;
    end
  end

  // Each sensor rise opens one output period of fixed high time
  assign spdIf.start = sensRise;
  assign spdIf.len = width_ff;

  // Distance: add 4000 per sensor pulse, emit an edge per k reached
  assign accSum = distAcc_ff + DIST_EDGES_PER_KM;
  assign distHit = sensRise && (accSum >= {1'b0, kEff});

  always_comb begin
    nxt_distAcc = distAcc_ff;
    nxt_distPend = distPend_ff;
    if (distIf.start) begin
      nxt_distPend = 1'b0;
    end
    if (sensRise) begin
      if (distHit) begin
        nxt_distAcc = accSum - {1'b0, kEff};
        nxt_distPend = 1'b1;                 // Set wins over clear
      end else begin
        nxt_distAcc = accSum;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      distAcc_ff <= 16'h0;
      distPend_ff <= 1'b0;
    end else begin
      distAcc_ff <= nxt_distAcc;
      distPend_ff <= nxt_distPend;
    end
  end

  // Launch only from low, so every edge is a real rising edge
  assign distIf.start = distPend_ff && !distIf.active;
  assign distIf.len = DIST_LEN;

  spg_pulse_timer #(.W(SPD_W)) uSpdTimer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pif(spdIf.timer)
  );

  spg_pulse_timer #(.W(SPD_W)) uDistTimer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pif(distIf.timer)
  );

  assign speedOut = spdIf.active;
  assign distanceOut = distIf.active;

  // Output follows an accepted sensor rise on the next edge
  a_spd_edge_latency: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    sensRise |=> speedOut)
    else $error("speed output missed a sensor edge");

  // Every output period is opened by a sensor period
  a_spd_period_cause: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(speedOut) |-> $past(sensRise))
    else $error("speed pulse without sensor edge");

  // Width stays within 0.64 ms to 4 ms
  a_spd_width_range: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (width_ff >= SPD_WIDTH_MIN) && (width_ff <= SPD_WIDTH_RST))
    else $error("speed width out of range");

  // A new constant yields a new width after 33 cycles
  a_div_new_width: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    divStart |-> ##33 ((divState_ff == DIV_IDLE)
      && (divK_ff == $past(kEff, 33))))
    else $error("width divider timing wrong");

  // Reaching k accumulated counts queues one distance edge
  a_dist_accum_hit: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    distHit |=> distPend_ff || distanceOut)
    else $error("distance edge lost");

  // A queued edge goes out at once when the output is low
  a_dist_edge_out: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (distPend_ff && !distanceOut) |=> distanceOut ##1 distanceOut)
    else $error("queued distance edge not sent");

  // Distance pulses stay high for at least 8 cycles
  a_dist_min_high: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(distanceOut) |-> distanceOut [*8])
    else $error("distance pulse too short");

endmodule // spg_speed_pulse_gen

// ### verification/spg_sensor_model.sv
`timescale 1ns/1ps
// Motion sensor: bursts of square speed pulses, low between bursts
module spg_sensor_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic go,             // One-cycle burst request
  input wire logic [15:0] period,  // Cycles per pulse, at least 4
  input wire logic [15:0] count,   // Pulses in the burst
  output logic sensorIn,           // Speed signal, low when standing
  output logic busy                // Burst in progress
);
  int phase;  // Cycle within the current pulse
  int left;   // Pulses still to send
  // High for the first half of each period, low once the burst ends
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sensorIn <= 1'b0;
      busy <= 1'b0;
      phase <= 0;
      left <= 0;
    end else if (go) begin
      busy <= 1'b1;
      left <= int'(count);
      phase <= 0;
    end else if (left != 0) begin
      sensorIn <= (phase < int'(period) / 2);
      if (phase == int'(period) - 1) begin
        phase <= 0;
        left <= left - 1;
      end else begin
        phase <= phase + 1;
      end
    end else begin
      // Vehicle stands: the line rests low
      sensorIn <= 1'b0;
      busy <= 1'b0;
    end
  end
endmodule // spg_sensor_model

// ### verification/testbench.sv
`timescale 1ns/1ps
// Speed and distance regenerator bench
module testbench
  import spg_pkg::*;
;
  localparam int DIST_CYC = 20;  // Short distance pulse keeps the run brief
  logic ref_clk, rst_n, go, sensorIn, sensBusy, speedOut, distanceOut;
  logic [K_W-1:0] pulsesPerKm;  // Constant k
  logic [15:0] period, count;   // Burst shape for the sensor
  int err_count, checks_done;
  int distRises, distHigh;      // Distance pulse monitor
  logic distPrev;
  int rem;                      // Accumulator remainder expected

  spg_speed_pulse_gen #(.DIST_PULSE_CYC(DIST_CYC)) spg_speed_pulse_gen_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .sensorIn(sensorIn),
    .pulsesPerKm(pulsesPerKm), .speedOut(speedOut),
    .distanceOut(distanceOut));
  spg_sensor_model spg_sensor_model_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .go(go), .period(period),
    .count(count), .sensorIn(sensorIn), .busy(sensBusy));

  // Clock, 10 ns period
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Observe on the falling edge, where flop outputs are settled
  always @(negedge ref_clk) begin
    distPrev <= distanceOut;
    if (distanceOut === 1'b1) distHigh <= distHigh + 1;
    if (distanceOut === 1'b1 && distPrev === 1'b0) begin
      distRises <= distRises + 1;
    end
    if (distanceOut === 1'b0 && distPrev === 1'b1) begin
      check(distHigh, DIST_CYC, "distance width");
      distHigh <= 0;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic conclude();
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Launch a burst and wait for the sensor to fall quiet
  task automatic burst(input int per, input int n);
    int i;
    @(posedge ref_clk);
    period <= 16'(per);
    count <= 16'(n);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    for (i = 0; i < per * n + 10; i++) begin
      @(negedge ref_clk);
      if (sensBusy === 1'b0) break;
    end
    if (i == per * n + 10) begin
      err_count++;
      conclude();
    end
  endtask

  // One sensor pulse at k = 25000: latency and high time
  task automatic speed_scn();
    int w, lat, wid;
    w = 0;
    lat = 0;
    wid = 0;
    @(posedge ref_clk);
    period <= 16'h0014;
    count <= 16'h0001;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    // Latency counts from the pin's rise, not from the burst request
    while (sensorIn !== 1'b1 && w < 10) begin
      @(negedge ref_clk);
      w++;
    end
    while (speedOut !== 1'b1 && lat < 6000) begin
      @(negedge ref_clk);
      lat++;
    end
    check(lat <= 5000 && w < 10, 1'b1, "speed latency");
    while (speedOut === 1'b1 && wid < 70000) begin
      @(negedge ref_clk);
      wid++;
    end
    check(wid, 16000 * CYC_PER_MS / 25000, "speed width");
    // A wait that ran out has already counted a mismatch
    if (w == 10 || lat == 6000 || wid == 70000) conclude();
    rem = 4000;  // That pulse already fed the distance accumulator
  endtask

  // Distance edges for several k, the last one out of range and clamped
  task automatic dist_scn();
    int ks[3], ns[3], i, j, keff, base, exp;
    ks = '{25000, 4000, 32767};
    ns = '{25, 10, 25};
    for (j = 0; j < 3; j++) begin
      @(posedge ref_clk);
      pulsesPerKm <= K_W'(ks[j]);
      repeat (40) @(posedge ref_clk);  // Let the width division finish
      keff = (ks[j] > 25000) ? 25000 : ks[j];
      // Each sensor pulse adds 4000 and yields at most one edge, so a
      // remainder carried into a smaller k is not paid out at once
      exp = 0;
      for (i = 0; i < ns[j]; i++) begin
        rem = rem + 4000;
        if (rem >= keff) begin
          rem = rem - keff;
          exp++;
        end
      end
      base = distRises;
      burst(100, ns[j]);
      repeat (40) @(negedge ref_clk);
      check(distRises - base, exp, "distance count");
    end
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    period = 16'h0064;
    count = 16'h0000;
    pulsesPerKm = 15'h61a8;
    err_count = 0;
    checks_done = 0;
    distRises = 0;
    distHigh = 0;
    distPrev = 1'b0;
    rem = 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (50) @(posedge ref_clk);
    speed_scn();
    dist_scn();
    conclude();
  end
endmodule // testbench
